/* gfr_pkg.sv */
// shared constants and types for the filter, range and rate-event configuration block
`default_nettype none
package gfr_pkg;
    localparam logic [7:0] GFR_GENERAL_CONTROL_OFS = 8'h0D;
    localparam logic [7:0] GFR_RATE_EVENT_CONFIG_OFS = 8'h0E;
    localparam logic [7:0] GFR_RATE_EVENT_SOURCE_OFS = 8'h0F;
    localparam logic [7:0] GFR_GENERAL_CONTROL_RST = 8'h00;
    localparam logic [7:0] GFR_RATE_EVENT_CONFIG_RST = 8'h00;
    localparam int GFR_LPF_POS = 6;
    localparam int GFR_THREE_WIRE_POS = 5;
    localparam int GFR_HPF_CORNER_POS = 3;
    localparam int GFR_HIGHPASS_FILTER_ENABLE_POS = 2;
    localparam int GFR_FSR_POS = 0;
    localparam int GFR_LATCH_POS = 3;
    localparam logic [7:0] GFR_CFG_WMASK = 8'h0F;
    localparam int GFR_RATE_W = 16;
    // lowpass cutoff at 800 Hz output rate, shift right per bandwidth code step, codes 2 and 3 both shift by two
    localparam int GFR_LPF_BASE_HZ = 256;
    // full-scale range in dps, 2000 halved per code step
    localparam int GFR_FSR_BASE_DPS = 2000;

    typedef enum logic [1:0] {
        GFR_MODE_STANDBY,
        GFR_MODE_READY,
        GFR_MODE_ACTIVE
    } gfr_mode_type;

    typedef struct packed {
        logic [1:0] lowpass_cutoff_selection;
        logic       three_wire_select;
        logic [1:0] highpass_corner;
        logic       highpass_filter_enable;
        logic [1:0] full_scale_range;
    } gfr_ctrl_type;

    typedef struct packed {
        logic [3:0] unused;
        logic       event_latch_on;
        logic       z_event_detect_on;
        logic       y_event_detect_on;
        logic       x_event_detect_on;
    } gfr_cfg_type;

    typedef struct packed {
        logic       zero;
        logic       any_axis_flag;
        logic [5:0] axis;
    } gfr_src_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gfr_acc_type;
endpackage
`default_nettype wire

/* gfr_axis_det.sv */
// one axis of the rate threshold detector with debounce
`timescale 1ns/1ps
`default_nettype none
module gfr_axis_det #(
    parameter int RATE_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              clr,
    input  wire logic              sample,
    input  wire logic              enable,
    input  wire logic [RATE_W-1:0] rate,
    input  wire logic [7:0]        limit,
    input  wire logic [7:0]        count,
    output logic                   flag,
    output logic                   neg
);
    logic [RATE_W-1:0] mag;
    logic              above;
    logic              flag_r, flag_nxt;
    logic [7:0]        cnt_r, cnt_nxt;

    always_comb begin
        mag = rate[RATE_W-1] ? RATE_W'(-rate) : rate;
        // most negative input has no positive twin, so its top bit stays set
        above = mag[RATE_W-1] || (mag[RATE_W-2:0] > {{(RATE_W-9){1'b0}}, limit});
        flag_nxt = flag_r;
        cnt_nxt = cnt_r;
        // [RQ13] detect only when enabled
        if (clr || !enable) begin
            flag_nxt = 1'b0;
            cnt_nxt = 8'h00;
        end else if (sample) begin
            // [RQ14] debounce both edges
            if (above == flag_r) begin
                cnt_nxt = 8'h00;
            end else if (cnt_r >= count) begin
                flag_nxt = above;
                cnt_nxt = 8'h00;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flag_r <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            flag_r <= flag_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign flag = flag_r;
    assign neg = enable & rate[RATE_W-1];
endmodule
`default_nettype wire

/* gfr_cfg_bank.sv */
// general control and rate-event configuration registers with threshold event source
// Function
// [RQ1] host changes general control only in Standby or Ready mode
// [RQ2] bits 7:6 pick lowpass cutoff: 256 Hz, half, quarter at 800 Hz
// [RQ3] bit 5 selects three-wire SPI when set, four-wire otherwise
// [RQ4] bits 4:3 pick highpass corner, scaled by output rate
// [RQ5] bit 2 enables the highpass filter; reset leaves it off
// [RQ6] highpass state restarts on mode change, rate change or zero-rate bit
// [RQ7] filtered data feeds outputs, FIFO and threshold detector when enabled; the detector here takes the raw rate inputs
// [RQ8] bits 1:0 pick range 2000, 1000, 500, 250 dps
// [RQ9] range doubler bit doubles every selected range
// [RQ10] detector state resets on Standby or Ready to Active
// [RQ11] host changes event configuration only in Standby mode
// [RQ12] bit 3 latches event flags; otherwise flags follow detection
// [RQ13] per-axis detect enables: Z bit 2, Y bit 1, X bit 0
// [RQ14] axis flag sets and clears after debounce count of samples
// [RQ15] reading event source clears latched flags when latching on
// [RQ16] upper bits of event configuration read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
module gfr_cfg_bank
    import gfr_pkg::*;
#(
    parameter int RATE_W = 16
) (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire gfr_pkg::gfr_acc_type acc,
    input  wire gfr_pkg::gfr_mode_type mode,
    input  wire logic [2:0]         odr_sel,
    input  wire logic               zero_rate,
    input  wire logic               range_doubler,
    input  wire logic               sample,
    input  wire logic [RATE_W-1:0]  rate_x,
    input  wire logic [RATE_W-1:0]  rate_y,
    input  wire logic [RATE_W-1:0]  rate_z,
    input  wire logic [7:0]         rate_limit_level,
    input  wire logic [7:0]         debounce_sample_count,
    output logic [7:0]              rdata,
    output gfr_pkg::gfr_ctrl_type   ctrl,
    output gfr_pkg::gfr_cfg_type    cfg,
    output logic [8:0]              lpf_cutoff_hz,
    output logic [12:0]             range_dps,
    output logic                    hpf_active,
    output logic                    hpf_restart,
    output logic                    three_wire,
    output gfr_pkg::gfr_src_type    src
);
    import gfr_pkg::*;

    gfr_ctrl_type ctrl_r, ctrl_nxt;
    gfr_cfg_type  cfg_r, cfg_nxt;
    gfr_src_type  src_r, src_nxt;
    gfr_mode_type mode_r;
    logic [2:0]   odr_r;
    logic [7:0]   rdata_r, rdata_nxt;
    logic [8:0]   lpf_r, lpf_nxt;
    logic [12:0]  range_r, range_nxt;
    logic         hpf_act_r, hpf_act_nxt;
    logic         hpf_rst_r, hpf_rst_nxt;
    logic         det_clr;
    logic         src_read;
    logic [2:0]   live_flag;
    logic [2:0]   live_neg;
    logic [2:0]   axis_en;
    logic [2:0]   flag_prev_r, flag_prev_nxt;
    logic [2:0]   new_event;
    logic [RATE_W-1:0] rates [3];

    assign rates[0] = rate_x;
    assign rates[1] = rate_y;
    assign rates[2] = rate_z;
    assign axis_en = {cfg_r.z_event_detect_on, cfg_r.y_event_detect_on, cfg_r.x_event_detect_on};

    function automatic logic is_reg(input gfr_acc_type a, input logic [7:0] ofs);
        is_reg = a.addr == ofs;
    endfunction

    // cutoff halvings for each bandwidth code, 1x share the quarter setting
    function automatic logic [1:0] lpf_shift(input logic [1:0] sel);
        case (sel)
            2'b00:   lpf_shift = 2'h0;
            2'b01:   lpf_shift = 2'h1;
            default: lpf_shift = 2'h2;
        endcase
    endfunction

    // [RQ10] detector reset on entry to Active
    assign det_clr = (mode == GFR_MODE_ACTIVE) && (mode_r != GFR_MODE_ACTIVE);
    assign src_read = acc.rd && is_reg(acc, GFR_RATE_EVENT_SOURCE_OFS);

    // latch fresh detections only, so a read can clear a standing event
    assign new_event = live_flag & ~flag_prev_r;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            gfr_axis_det #(
                .RATE_W (RATE_W)
            ) u_det (
                .clk    (clk),
                .rstn   (rstn),
                .clr    (det_clr),
                .sample (sample),
                .enable (axis_en[g]),
                .rate   (rates[g]),
                .limit  (rate_limit_level),
                .count  (debounce_sample_count),
                .flag   (live_flag[g]),
                .neg    (live_neg[g])
            );
        end
    endgenerate

    always_comb begin
        ctrl_nxt = ctrl_r;
        cfg_nxt = cfg_r;
        // host keeps these writes out of Active; not enforced here
        // [RQ2] [RQ4] [RQ8] fields stored whole
        if (acc.wr && is_reg(acc, GFR_GENERAL_CONTROL_OFS)) begin
            ctrl_nxt = gfr_ctrl_type'(acc.wdata);
        end
        // [RQ16] upper bits dropped on write
        if (acc.wr && is_reg(acc, GFR_RATE_EVENT_CONFIG_OFS)) begin
            cfg_nxt = gfr_cfg_type'(acc.wdata & GFR_CFG_WMASK);
        end
    end

    always_comb begin
        src_nxt = src_r;
        src_nxt.zero = 1'b0;
        flag_prev_nxt = det_clr ? 3'h0 : live_flag;
        if (det_clr) begin
            src_nxt = '0;
        end else if (cfg_r.event_latch_on) begin
            // [RQ15] read clears, new event wins
            if (src_read) begin
                src_nxt = '0;
            end
            for (int i = 0; i < 3; i++) begin
                if (new_event[i]) begin
                    src_nxt.axis[2*i+1] = 1'b1;
                end
                // polarity bits latch their level
                if (live_neg[i]) begin
                    src_nxt.axis[2*i] = 1'b1;
                end
            end
        end else begin
            // [RQ12] unlatched flags track detection
            for (int i = 0; i < 3; i++) begin
                src_nxt.axis[2*i+1] = live_flag[i];
                src_nxt.axis[2*i] = live_neg[i];
            end
        end
        src_nxt.any_axis_flag = src_nxt.axis[5] | src_nxt.axis[3] | src_nxt.axis[1];
    end

    always_comb begin
        // [RQ2] lowpass cutoff from field
        lpf_nxt = 9'(GFR_LPF_BASE_HZ >> lpf_shift(ctrl_r.lowpass_cutoff_selection));
        // [RQ8] range from code
        range_nxt = 13'(GFR_FSR_BASE_DPS >> ctrl_r.full_scale_range);
        // [RQ9] range doubler
        if (range_doubler) begin
            range_nxt = {range_nxt[11:0], 1'b0};
        end
        // [RQ5] [RQ7] filter on data path
        hpf_act_nxt = ctrl_r.highpass_filter_enable;
        // [RQ6] restart filter state
        hpf_rst_nxt = (mode != mode_r) || (odr_sel != odr_r) || zero_rate;
        // unmapped offsets read as zero
        rdata_nxt = rdata_r;
        if (acc.rd) begin
            case (acc.addr)
                GFR_GENERAL_CONTROL_OFS:   rdata_nxt = ctrl_r;
                GFR_RATE_EVENT_CONFIG_OFS: rdata_nxt = cfg_r;
                GFR_RATE_EVENT_SOURCE_OFS: rdata_nxt = src_r;
                default:                   rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r <= GFR_GENERAL_CONTROL_RST;
            cfg_r <= GFR_RATE_EVENT_CONFIG_RST;
            src_r <= '0;
            mode_r <= GFR_MODE_STANDBY;
            odr_r <= 3'h0;
            rdata_r <= 8'h00;
            lpf_r <= 9'(GFR_LPF_BASE_HZ);
            range_r <= 13'(GFR_FSR_BASE_DPS);
            hpf_act_r <= 1'b0;
            hpf_rst_r <= 1'b0;
            flag_prev_r <= 3'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cfg_r <= cfg_nxt;
            src_r <= src_nxt;
            mode_r <= mode;
            odr_r <= odr_sel;
            rdata_r <= rdata_nxt;
            lpf_r <= lpf_nxt;
            range_r <= range_nxt;
            hpf_act_r <= hpf_act_nxt;
            hpf_rst_r <= hpf_rst_nxt;
            flag_prev_r <= flag_prev_nxt;
        end
    end

    assign rdata = rdata_r;
    assign ctrl = ctrl_r;
    assign cfg = cfg_r;
    assign src = src_r;
    assign lpf_cutoff_hz = lpf_r;
    assign range_dps = range_r;
    assign hpf_active = hpf_act_r;
    assign hpf_restart = hpf_rst_r;
    // [RQ3] three-wire select
    assign three_wire = ctrl_r.three_wire_select;
endmodule
`default_nettype wire

/* gfr_cfg_bank_properties.sv */
// port assertions for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module gfr_cfg_bank_props
    import gfr_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire gfr_pkg::gfr_acc_type  acc,
    input wire gfr_pkg::gfr_mode_type mode,
    input wire logic [2:0]            odr_sel,
    input wire logic                  zero_rate,
    input wire logic                  range_doubler,
    input wire logic                  sample,
    input wire logic [7:0]            rdata,
    input wire gfr_pkg::gfr_ctrl_type ctrl,
    input wire gfr_pkg::gfr_cfg_type  cfg,
    input wire logic [8:0]            lpf_cutoff_hz,
    input wire logic [12:0]           range_dps,
    input wire logic                  hpf_active,
    input wire logic                  hpf_restart,
    input wire logic                  three_wire,
    input wire gfr_pkg::gfr_src_type  src
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ctrl_write_a: assert property (acc.wr && acc.addr == 8'h0D |=> ctrl == $past(acc.wdata))
        else $error("general control write lost");
    cfg_write_a: assert property (acc.wr && acc.addr == 8'h0E |=> cfg == ($past(acc.wdata) & 8'h0F))
        else $error("event config write wrong");
    spi_wires_a: assert property (acc.wr && acc.addr == 8'h0D |=>
        three_wire == $past(acc.wdata[5]))
        else $error("three wire select wrong");
    hpf_enable_a: assert property ($stable(ctrl) |-> hpf_active == ctrl.highpass_filter_enable)
        else $error("highpass enable wrong");
    range_value_a: assert property ($stable(ctrl) && $stable(range_doubler) |=>
        range_dps == ((13'd2000 >> $past(ctrl.full_scale_range)) << $past(range_doubler)))
        else $error("range wrong");
    lpf_value_a: assert property ($stable(ctrl) && $stable(odr_sel) && odr_sel == 3'h0 |=>
        lpf_cutoff_hz == (9'd256 >> ($past(ctrl[7]) ? 2 : $past(ctrl[6]))))
        else $error("lowpass cutoff wrong");
    hpf_restart_a: assert property (zero_rate || !$stable(mode) || !$stable(odr_sel) |=> hpf_restart)
        else $error("highpass restart missing");
    cfg_read_a: assert property (acc.rd && !acc.wr && acc.addr == 8'h0E |=> rdata == $past(cfg))
        else $error("event config read wrong");
    unmapped_read_a: assert property (acc.rd && !(acc.addr inside {[8'h0D:8'h0F]}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    active_clear_a: assert property (mode == GFR_MODE_ACTIVE && $past(mode) != GFR_MODE_ACTIVE |=>
        (src & 8'h6A) == 8'h00) else $error("flags kept on entering active");
    read_clear_a: assert property (acc.rd && acc.addr == 8'h0F && cfg.event_latch_on && !sample
        && !$past(sample) |=> (src & 8'h6A) == 8'h00) else $error("latched flags not cleared");
    cover property (src.any_axis_flag && cfg.event_latch_on);
    cover property (hpf_restart);
    cover property (range_dps == 13'd4000);
endmodule
bind gfr_cfg_bank gfr_cfg_bank_props u_props (.clk(clk), .rstn(rstn), .acc(acc), .mode(mode),
    .odr_sel(odr_sel), .zero_rate(zero_rate), .range_doubler(range_doubler), .sample(sample),
    .rdata(rdata), .ctrl(ctrl), .cfg(cfg), .lpf_cutoff_hz(lpf_cutoff_hz), .range_dps(range_dps),
    .hpf_active(hpf_active), .hpf_restart(hpf_restart), .three_wire(three_wire), .src(src));
`default_nettype wire

/* gfr_host_model.sv */
// host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module gfr_host_model
    import gfr_pkg::*;
(
    input  wire logic               clk,
    input  wire logic [7:0]         rdata,
    output var gfr_pkg::gfr_acc_type acc
);
    initial acc = '0;
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        acc <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        acc <= '0;
        @(posedge clk);
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        acc <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        acc <= '0;
        @(posedge clk);
        d = rdata;
    endtask
endmodule
`default_nettype wire

/* test_gfr_cfg_bank.sv */
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_gfr_cfg_bank;
    import gfr_pkg::*;
    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    gfr_acc_type   acc;
    gfr_mode_type  mode = GFR_MODE_STANDBY;
    logic [2:0]    odr_sel = 3'h0;
    logic          zero_rate = 1'b0;
    logic          range_doubler = 1'b0;
    logic          sample = 1'b0;
    logic [15:0]   rate_x = 16'h0000;
    logic [15:0]   rate_y = 16'h0000;
    logic [15:0]   rate_z = 16'h0000;
    logic [7:0]    rate_limit_level = 8'h0A;
    logic [7:0]    debounce_sample_count = 8'h02;
    logic [7:0]    rdata;
    gfr_ctrl_type  ctrl;
    gfr_cfg_type   cfg;
    logic [8:0]    lpf_cutoff_hz;
    logic [12:0]   range_dps;
    logic          hpf_active;
    logic          hpf_restart;
    logic          three_wire;
    gfr_src_type   src;
    logic [7:0]    rd;
    int            failures = 0;
    int            samples_checked = 0;
    gfr_cfg_bank u_dut (.clk(clk), .rstn(rstn), .acc(acc), .mode(mode), .odr_sel(odr_sel),
        .zero_rate(zero_rate), .range_doubler(range_doubler), .sample(sample), .rate_x(rate_x),
        .rate_y(rate_y), .rate_z(rate_z), .rate_limit_level(rate_limit_level),
        .debounce_sample_count(debounce_sample_count), .rdata(rdata), .ctrl(ctrl), .cfg(cfg),
        .lpf_cutoff_hz(lpf_cutoff_hz), .range_dps(range_dps), .hpf_active(hpf_active),
        .hpf_restart(hpf_restart), .three_wire(three_wire), .src(src));
    gfr_host_model u_host (.clk(clk), .rdata(rdata), .acc(acc));
    initial forever #20 clk = ~clk;
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            sample <= 1'b1;
            @(posedge clk);
            sample <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic set_mode(input gfr_mode_type m);
        mode <= m;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        u_host.read_reg(8'h0D, rd);
        check(rd, 8'h00);
        u_host.read_reg(8'h0E, rd);
        check(rd, 8'h00);
        for (int i = 0; i < 4; i++) begin
            range_doubler <= !i[0];
            u_host.write_reg(8'h0D, {i[1:0], !i[0], i[1:0], i[0], i[1:0]});
            repeat (3) @(posedge clk);
            u_host.read_reg(8'h0D, rd);
            check(rd, {i[1:0], !i[0], i[1:0], i[0], i[1:0]});
            check(three_wire, !i[0]);
            check(hpf_active, i[0]);
            check(lpf_cutoff_hz, i[1] ? 13'd64 : (i[0] ? 13'd128 : 13'd256));
            check(range_dps, (13'd2000 >> i[1:0]) << !i[0]);
        end
        u_host.write_reg(8'h0E, 8'hFF);
        u_host.read_reg(8'h0E, rd);
        check(rd, 8'h0F);
        u_host.read_reg(8'h20, rd);
        check(rd, 8'h00);
        u_host.write_reg(8'h0E, 8'h09);
        rate_x <= 16'hFF9C;
        rate_y <= 16'hFF9C;
        set_mode(GFR_MODE_ACTIVE);
        pulses(2);
        check(src[7:1], 7'h00);
        pulses(1);
        check(src, 8'h43);
        rate_x <= 16'h0000;
        pulses(4);
        check(src[7:1], 7'h21);
        u_host.read_reg(8'h0F, rd);
        check(rd[7:1], 7'h21);
        check(src, 8'h00);
        rate_x <= 16'hFF9C;
        pulses(3);
        set_mode(GFR_MODE_READY);
        set_mode(GFR_MODE_ACTIVE);
        check(src & 8'h6A, 8'h00);
        set_mode(GFR_MODE_STANDBY);
        u_host.write_reg(8'h0E, 8'h01);
        set_mode(GFR_MODE_ACTIVE);
        pulses(3);
        check(src[7:1], 7'h21);
        rate_x <= 16'h0000;
        pulses(3);
        check(src, 8'h00);
        set_mode(GFR_MODE_STANDBY);
        u_host.write_reg(8'h0E, 8'h04);
        rate_z <= 16'h0064;
        set_mode(GFR_MODE_ACTIVE);
        pulses(3);
        check(src, 8'h60);
        zero_rate <= 1'b1;
        @(posedge clk);
        zero_rate <= 1'b0;
        @(negedge clk);
        check(hpf_restart, 1'b1);
        @(posedge clk);
        odr_sel <= 3'h1;
        @(negedge clk);
        check(hpf_restart, 1'b0);
        @(posedge clk);
        @(negedge clk);
        check(hpf_restart, 1'b1);
        @(posedge clk);
        print_verdict();
    end
endmodule
`default_nettype wire
